// *** rtl/idxpio_inq.sv ***
// idxpio_inq: sync, debounce and 30 ms qualify one active-low input
`timescale 1ns/100ps
module idxpio_inq #(
   parameter int unsigned QCYC = idxpio_pkg::QUAL_CYC,
   parameter int unsigned BCYC = idxpio_pkg::BOUNCE_CYC
) (
   input wire logic ref_clk,  // 25 MHz clock
   input wire logic rst_n,    // async reset, active low
   input wire logic pin_n,    // raw pin, low = asserted
   output logic level_r,      // qualified asserted level
   output logic pulse_r       // one pulse per qualified assertion
);
   logic s1_r;
   logic s2_r;
   logic stab_r;
   logic [idxpio_pkg::BW-1:0] bcnt_r;
   logic [idxpio_pkg::QW-1:0] qcnt_r;

   // two-flop synchroniser, idle high through pull-up
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         s1_r <= 1'b1;
         s2_r <= 1'b1;
      end else begin
         s1_r <= pin_n;
         s2_r <= s1_r;
      end
   end

   // bounce filter: level must hold for the bounce time
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         stab_r <= 1'b1;
         bcnt_r <= '0;
      end else if (s2_r == stab_r) begin
         bcnt_r <= '0;
      end else if (bcnt_r == idxpio_pkg::BW'(BCYC - 1)) begin
         stab_r <= s2_r;
         bcnt_r <= '0;
      end else begin
         bcnt_r <= bcnt_r + 1'b1;
      end
   end

   // low for 30 ms counts once per assertion
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         qcnt_r <= '0;
         level_r <= 1'b0;
         pulse_r <= 1'b0;
      end else begin
         pulse_r <= 1'b0;
         if (stab_r) begin
            qcnt_r <= '0;
            level_r <= 1'b0;
         end else if (!level_r) begin
            if (qcnt_r == idxpio_pkg::QW'(QCYC - 1)) begin
               level_r <= 1'b1;
               pulse_r <= 1'b1;
            end else begin
               qcnt_r <= qcnt_r + 1'b1;
            end
         end
      end
   end

   // a pulse only ever comes with the level rising
   a_pulse_once: assert property (@(posedge ref_clk) disable iff (!rst_n)
      pulse_r |-> level_r && !$past(level_r))
      else $error("qualified pulse without new level");
   // high filtered input never yields a level
   a_idle_high: assert property (@(posedge ref_clk) disable iff (!rst_n)
      stab_r |=> !level_r)
      else $error("level while filtered input high");
endmodule : idxpio_inq

// *** rtl/idxpio_pkg.sv ***
// idxpio_pkg: constants and types for the indexer parallel i/o block
package idxpio_pkg;
   // input modes other than lockout, kept across power cycles by the caller's storage
   typedef enum logic [1:0] {
      IDXPIO_MODE_BCD = 2'h0,
      IDXPIO_MODE_LOCK = 2'h1,
      IDXPIO_MODE_ONEHOT = 2'h3,
      IDXPIO_MODE_BIN = 2'h2
   } idxpio_mode_t;
   localparam idxpio_mode_t IDXPIO_MODE_RST = IDXPIO_MODE_BCD;
   // timing
   localparam int unsigned CLK_HZ = 25_000_000;
   localparam int unsigned QUAL_MS = 30;
   localparam int unsigned QUAL_CYC = CLK_HZ / 1000 * QUAL_MS;
   localparam int unsigned BOUNCE_US = 1000;
   localparam int unsigned BOUNCE_CYC = CLK_HZ / 1_000_000 * BOUNCE_US;
   localparam int QW = 20;
   localparam int BW = 15;
   // position widths and values
   localparam int PW = 8;
   localparam logic [7:0] POS_NONE = 8'h00;
   localparam logic [7:0] POS_ONE = 8'h01;
   localparam logic [7:0] POS_MAX_1H = 8'h08;
   localparam logic [3:0] BCD_MAX = 4'h9;
   localparam logic [3:0] DEC_TEN = 4'hA;
   localparam logic [7:0] OUT_IDLE = 8'hFF;
endpackage : idxpio_pkg

// *** rtl/idxpio_top.sv ***
// idxpio_top: parallel digital i/o front end of the valve indexer
`timescale 1ns/100ps
module idxpio_top #(
   parameter int unsigned QCYC = idxpio_pkg::QUAL_CYC,  // 30 ms count
   parameter int unsigned BCYC = idxpio_pkg::BOUNCE_CYC // bounce count
) (
   input wire logic ref_clk,             // 25 MHz clock
   input wire logic rst_n,               // power-up reset, active low
   input wire logic advance_n,           // step request pin
   input wire logic home_n,              // return-to-origin pin
   input wire logic manual_dir_n,        // manual direction pin
   input wire logic auto_dir_n,          // automatic direction pin
   input wire logic position_strobe_n,   // data latch pin
   input wire logic [7:0] sel_n,         // position select pins
   input wire logic mode_wr,             // mode write strobe
   input wire idxpio_pkg::idxpio_mode_t mode_in, // mode to write
   input wire idxpio_pkg::idxpio_mode_t mode_nv, // stored mode at boot
   input wire logic [7:0] cfg_count,     // configured position count
   input wire logic [7:0] cfg_offset,    // configured offset
   input wire logic [7:0] cur_pos,       // current position, binary
   input wire logic motor_busy,          // motor turning
   input wire logic cur_dir,             // rotation direction
   input wire logic move_fault,          // rotor out of position
   output logic advance_req_r,           // step request pulse
   output logic home_req_r,              // home request pulse
   output logic dir_toggle_r,            // manual direction pulse
   output logic auto_dir_r,              // automatic direction level
   output logic goto_req_r,              // move request pulse
   output logic [7:0] goto_pos_r,        // target position
   output idxpio_pkg::idxpio_mode_t mode_r, // active input mode
   output logic mode_save_r,             // store mode pulse
   output logic [7:0] eff_count_r,       // effective count
   output logic [7:0] eff_offset_r,      // effective offset
   output logic [7:0] pos_out_n_r,       // position lines, active low
   output logic drive_active_n_r,        // motor running, active low
   output logic dir_out_n_r,             // direction, active low
   output logic error_n_r                // error, active low
);
   localparam int NQ = 5;
   logic [NQ-1:0] q_pin;
   logic [NQ-1:0] q_lvl;
   logic [NQ-1:0] q_pls;
   logic [7:0] sel_s1_r;
   logic [7:0] sel_s2_r;
   logic boot_r;
   logic [7:0] dec_nxt;
   logic dec_ok_nxt;
   logic [7:0] bcd_nxt;
   logic [7:0] sel;
   logic lock;

   // pins already wired-or low on the shared connector
   assign q_pin = {auto_dir_n, manual_dir_n, position_strobe_n,
                   home_n, advance_n};
   assign lock = (mode_r == idxpio_pkg::IDXPIO_MODE_LOCK);

   // one qualifier per control input
   for (genvar i = 0; i < NQ; i++) begin : g_q
      idxpio_inq #(.QCYC(QCYC), .BCYC(BCYC)) u_q (
         .ref_clk(ref_clk),
         .rst_n(rst_n),
         .pin_n(q_pin[i]),
         .level_r(q_lvl[i]),
         .pulse_r(q_pls[i])
      );
   end

   // select lines through two flops, made active high
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         sel_s1_r <= idxpio_pkg::OUT_IDLE;
         sel_s2_r <= idxpio_pkg::OUT_IDLE;
      end else begin
         sel_s1_r <= sel_n;
         sel_s2_r <= sel_s1_r;
      end
   end
   assign sel = ~sel_s2_r;

   // mode: nonvolatile value at boot, lockout falls back to BCD
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         boot_r <= 1'b1;
         mode_r <= idxpio_pkg::IDXPIO_MODE_RST;
         mode_save_r <= 1'b0;
      end else begin
         boot_r <= 1'b0;
         mode_save_r <= 1'b0;
         if (boot_r) begin
            mode_r <= (mode_nv == idxpio_pkg::IDXPIO_MODE_LOCK) ?
                      idxpio_pkg::IDXPIO_MODE_BCD : mode_nv;
         end else if (mode_wr) begin
            mode_r <= mode_in;
            mode_save_r <= 1'b1;
         end
      end
   end

   // one-hot mode forces offset one and caps count at eight
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         eff_count_r <= idxpio_pkg::POS_MAX_1H;
         eff_offset_r <= idxpio_pkg::POS_ONE;
      end else if (mode_r == idxpio_pkg::IDXPIO_MODE_ONEHOT) begin
         eff_offset_r <= idxpio_pkg::POS_ONE;
         eff_count_r <= (cfg_count > idxpio_pkg::POS_MAX_1H) ?
                        idxpio_pkg::POS_MAX_1H : cfg_count;
      end else begin
         eff_offset_r <= cfg_offset;
         eff_count_r <= cfg_count;
      end
   end

   // decode select lines by mode; weights 1..80 BCD
   always_comb begin
      dec_nxt = idxpio_pkg::POS_NONE;
      dec_ok_nxt = 1'b0;
      unique case (mode_r)
         idxpio_pkg::IDXPIO_MODE_BCD: begin
            dec_nxt = ({4'h0, sel[7:4]} * {4'h0, idxpio_pkg::DEC_TEN}) +
                      {4'h0, sel[3:0]};
            dec_ok_nxt = (sel[3:0] <= idxpio_pkg::BCD_MAX) &&
                         (sel[7:4] <= idxpio_pkg::BCD_MAX) &&
                         (sel != idxpio_pkg::POS_NONE);
         end
         idxpio_pkg::IDXPIO_MODE_ONEHOT: begin
            dec_ok_nxt = $onehot(sel);
            for (int k = 0; k < idxpio_pkg::PW; k++) begin
               if (sel[k]) begin
                  dec_nxt = 8'(k + 1);
               end
            end
         end
         idxpio_pkg::IDXPIO_MODE_BIN: begin
            dec_nxt = sel;
            dec_ok_nxt = (sel != idxpio_pkg::POS_NONE);
         end
         idxpio_pkg::IDXPIO_MODE_LOCK: begin
            dec_ok_nxt = 1'b0;
         end
      endcase
   end

   // requests; lockout drops all parallel inputs
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         advance_req_r <= 1'b0;
         home_req_r <= 1'b0;
         dir_toggle_r <= 1'b0;
         auto_dir_r <= 1'b0;
         goto_req_r <= 1'b0;
         goto_pos_r <= idxpio_pkg::POS_NONE;
      end else begin
         advance_req_r <= q_pls[0] && !lock;
         home_req_r <= q_pls[1] && !lock;
         dir_toggle_r <= q_pls[3] && !lock;
         auto_dir_r <= q_lvl[4] && !lock;
         goto_req_r <= q_pls[2] && !lock && dec_ok_nxt;
         if (q_pls[2] && !lock && dec_ok_nxt) begin
            goto_pos_r <= dec_nxt;
         end
      end
   end

   // binary position to two BCD digits for the output lines
   always_comb begin
      bcd_nxt = {4'(cur_pos / 8'(idxpio_pkg::DEC_TEN)),
                 4'(cur_pos % 8'(idxpio_pkg::DEC_TEN))};
   end

   // active-low status outputs
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         pos_out_n_r <= idxpio_pkg::OUT_IDLE;
         drive_active_n_r <= 1'b1;
         dir_out_n_r <= 1'b1;
         error_n_r <= 1'b1;
      end else begin
         pos_out_n_r <= move_fault ? idxpio_pkg::OUT_IDLE : ~bcd_nxt;
         drive_active_n_r <= !motor_busy;
         dir_out_n_r <= !cur_dir;
         error_n_r <= !move_fault;
      end
   end

   a_jam_zero: assert property (@(posedge ref_clk) disable iff (!rst_n)
      move_fault |=> pos_out_n_r == idxpio_pkg::OUT_IDLE)
      else $error("fault did not blank position");
   a_err_low: assert property (@(posedge ref_clk) disable iff (!rst_n)
      move_fault |=> !error_n_r)
      else $error("error output not asserted");
   a_run_low: assert property (@(posedge ref_clk) disable iff (!rst_n)
      motor_busy |=> !drive_active_n_r)
      else $error("run output not asserted");
   a_lock_quiet: assert property (@(posedge ref_clk) disable iff (!rst_n)
      $past(lock) |-> !goto_req_r && !advance_req_r && !home_req_r &&
      !dir_toggle_r && !auto_dir_r)
      else $error("request during lockout");
   a_count_cap: assert property (@(posedge ref_clk) disable iff (!rst_n)
      $past(mode_r) == idxpio_pkg::IDXPIO_MODE_ONEHOT |->
      eff_count_r <= idxpio_pkg::POS_MAX_1H &&
      eff_offset_r == idxpio_pkg::POS_ONE)
      else $error("one-hot limits not applied");
   a_onehot_pos: assert property (@(posedge ref_clk) disable iff (!rst_n)
      goto_req_r && $past(mode_r) == idxpio_pkg::IDXPIO_MODE_ONEHOT |->
      goto_pos_r >= idxpio_pkg::POS_ONE &&
      goto_pos_r <= idxpio_pkg::POS_MAX_1H)
      else $error("one-hot target out of range");
   a_goto_valid: assert property (@(posedge ref_clk) disable iff (!rst_n)
      goto_req_r |-> $past(dec_ok_nxt) && $past(q_pls[2]))
      else $error("move without valid strobe");
   a_boot_unlock: assert property (@(posedge ref_clk) disable iff (!rst_n)
      $past(boot_r) |-> mode_r != idxpio_pkg::IDXPIO_MODE_LOCK)
      else $error("lockout survived power-up");
endmodule : idxpio_top

// *** test/idxpio_ext_model.sv ***
// idxpio_ext_model: open-collector request source on five pins
`timescale 1ns/100ps
module idxpio_ext_model (
   input wire logic ref_clk,     // bench clock
   input wire logic [4:0] fire,  // start a low hold on a line
   input wire logic [7:0] len,   // hold length in cycles
   output logic [4:0] line_n     // 1 = released to pull-up
);
   logic [7:0] cnt_r [5] = '{default: 8'h00};
   // momentary low hold, then let go
   always_ff @(posedge ref_clk) begin
      for (int i = 0; i < 5; i++) begin
         if (fire[i]) begin
            cnt_r[i] <= len;
         end else if (cnt_r[i] != 8'h00) begin
            cnt_r[i] <= cnt_r[i] - 8'h01;
         end
      end
   end
   // line pulled low only while counting
   always_comb begin
      for (int i = 0; i < 5; i++) begin
         line_n[i] = (cnt_r[i] == 8'h00);
      end
   end
endmodule : idxpio_ext_model

// *** test/test_indexer_parallel_io.sv ***
// test_indexer_parallel_io: self-checking bench for idxpio_top
`timescale 1ns/100ps
module test_indexer_parallel_io;
   logic ref_clk, rst_n, mode_wr, motor_busy, cur_dir, move_fault;
   logic [7:0] sel_n, cfg_count, cfg_offset, cur_pos, len, v;
   logic [4:0] xf, mf, xl_n, ml_n;
   idxpio_pkg::idxpio_mode_t mode_in, mode_nv, md, mode_r;
   logic advance_req_r, home_req_r, dir_toggle_r, auto_dir_r;
   logic goto_req_r, mode_save_r, drive_active_n_r, dir_out_n_r;
   logic error_n_r;
   logic [7:0] goto_pos_r, eff_count_r, eff_offset_r, pos_out_n_r;
   logic [11:0] notes [$];
   int miscompares = 0, num_checks = 0, cycles = 0, seed = 56;

   idxpio_top #(.QCYC(8), .BCYC(4)) idxpio_top_i (
      .ref_clk(ref_clk), .rst_n(rst_n),
      .advance_n(xl_n[0] & ml_n[0]), .home_n(xl_n[1] & ml_n[1]),
      .manual_dir_n(xl_n[2]), .auto_dir_n(xl_n[3]),
      .position_strobe_n(xl_n[4]), .sel_n(sel_n), .mode_wr(mode_wr),
      .mode_in(mode_in), .mode_nv(mode_nv), .cfg_count(cfg_count),
      .cfg_offset(cfg_offset), .cur_pos(cur_pos),
      .motor_busy(motor_busy), .cur_dir(cur_dir),
      .move_fault(move_fault), .advance_req_r(advance_req_r),
      .home_req_r(home_req_r), .dir_toggle_r(dir_toggle_r),
      .auto_dir_r(auto_dir_r), .goto_req_r(goto_req_r),
      .goto_pos_r(goto_pos_r), .mode_r(mode_r),
      .mode_save_r(mode_save_r), .eff_count_r(eff_count_r),
      .eff_offset_r(eff_offset_r), .pos_out_n_r(pos_out_n_r),
      .drive_active_n_r(drive_active_n_r), .dir_out_n_r(dir_out_n_r),
      .error_n_r(error_n_r));
   idxpio_ext_model ext_i (.ref_clk(ref_clk), .fire(xf), .len(len),
      .line_n(xl_n));
   idxpio_ext_model man_i (.ref_clk(ref_clk), .fire(mf), .len(len),
      .line_n(ml_n));

   // 25 MHz clock
   initial begin
      ref_clk = 1'b0;
      forever #20 ref_clk = ~ref_clk;
   end

   task automatic test_done;
      $display("checks %0d miscompares %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : test_done

   task automatic cmp_stat(input logic [7:0] got, input logic [7:0] exp);
      num_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("unexpected %0t status %h want %h", $time, got, exp);
      end
   endtask : cmp_stat

   task automatic cmp_pulse(input logic [11:0] got);
      logic [11:0] exp;
      exp = 12'hFFF;
      num_checks++;
      if (notes.size() > 0) begin
         exp = notes.pop_front();
      end
      if (got !== exp) begin
         miscompares++;
         $display("unexpected %0t pulse %h want %h", $time, got, exp);
      end
   endtask : cmp_pulse

   // request pulses against the oldest note; cycle ceiling
   always @(negedge ref_clk) begin
      cycles++;
      if (cycles > 8000) begin
         miscompares++;
         test_done();
      end
      if ((advance_req_r | home_req_r | dir_toggle_r | goto_req_r)
          === 1'b1) begin
         cmp_pulse({advance_req_r, home_req_r, dir_toggle_r, goto_req_r,
            goto_req_r ? goto_pos_r : 8'h00});
      end
   end

   function automatic logic [11:0] want(input logic [7:0] s);
      logic [11:0] r;
      r = 12'h000;
      if (md == idxpio_pkg::IDXPIO_MODE_BCD && s[3:0] <= 4'h9 &&
          s[7:4] <= 4'h9 && s != 8'h00) begin
         r = {4'h1, s[7:4] * 8'h0A + s[3:0]};
      end
      if (md == idxpio_pkg::IDXPIO_MODE_ONEHOT && $onehot(s)) begin
         r = {4'h1, 8'h01 + 8'($clog2(s))};
      end
      if (md == idxpio_pkg::IDXPIO_MODE_BIN && s != 8'h00) begin
         r = {4'h1, s};
      end
      return r;
   endfunction : want

   // one line held low by one or both sources, then settle
   task automatic req(input int b, input logic [7:0] n, input logic man,
                      input logic [11:0] note);
      len = n;
      xf[b] = 1'b1;
      mf[b] = man;
      if (note !== 12'h000) begin
         notes.push_back(note);
      end
      @(posedge ref_clk);
      #1;
      xf = 5'h00;
      mf = 5'h00;
      repeat (n + 30) @(posedge ref_clk);
      #1;
   endtask : req

   task automatic set_mode(input idxpio_pkg::idxpio_mode_t m);
      mode_in = m;
      mode_wr = 1'b1;
      md = m;
      @(posedge ref_clk);
      #1;
      mode_wr = 1'b0;
      cmp_stat({7'h00, mode_save_r}, 8'h01);
      cmp_stat({6'h00, mode_r}, {6'h00, m});
      repeat (2) @(posedge ref_clk);
      #1;
      v = (m == idxpio_pkg::IDXPIO_MODE_ONEHOT) ? 8'h08 : cfg_count;
      cmp_stat(eff_count_r, v);
      v = (m == idxpio_pkg::IDXPIO_MODE_ONEHOT) ? 8'h01 : cfg_offset;
      cmp_stat(eff_offset_r, v);
   endtask : set_mode

   task automatic do_reset(input idxpio_pkg::idxpio_mode_t nv);
      rst_n = 1'b0;
      mode_nv = nv;
      repeat (2) @(posedge ref_clk);
      #1;
      cmp_stat(pos_out_n_r, 8'hFF);
      rst_n = 1'b1;
      repeat (3) @(posedge ref_clk);
      #1;
   endtask : do_reset

   // main sequence
   initial begin
      rst_n = 1'b0;
      xf = 5'h00;
      mf = 5'h00;
      len = 8'h00;
      sel_n = 8'hFF;
      mode_wr = 1'b0;
      mode_in = idxpio_pkg::IDXPIO_MODE_BCD;
      md = idxpio_pkg::IDXPIO_MODE_BCD;
      cfg_count = 8'h0C;
      cfg_offset = 8'h03;
      {cur_pos, motor_busy, cur_dir, move_fault} = 11'h000;
      do_reset(idxpio_pkg::IDXPIO_MODE_LOCK);
      cmp_stat({6'h00, mode_r}, 8'h00);
      req(0, 8'h14, 1'b0, 12'h800);
      req(0, 8'h06, 1'b0, 12'h000);
      req(1, 8'h14, 1'b1, 12'h400);
      req(0, 8'h14, 1'b1, 12'h800);
      req(2, 8'h14, 1'b0, 12'h200);
      len = 8'h30;
      xf[3] = 1'b1;
      repeat (30) @(posedge ref_clk);
      #1;
      xf[3] = 1'b0;
      cmp_stat({7'h00, auto_dir_r}, 8'h01);
      repeat (60) @(posedge ref_clk);
      #1;
      cmp_stat({7'h00, auto_dir_r}, 8'h00);
      for (int k = 0; k < 4; k++) begin
         set_mode(idxpio_pkg::idxpio_mode_t'(k));
         req(0, 8'h14, 1'b0, (k == 1) ? 12'h000 : 12'h800);
         for (int j = 0; j < 13; j++) begin
            v = 8'($random(seed));
            if (j < 5) begin
               v = (8'h00 << (j * 8)) | 8'({8'h03, 8'h80, 8'h1A,
                  8'h99, 8'h00} >> (j * 8));
            end
            sel_n = ~v;
            req(4, 8'h14, 1'b0, want(v));
         end
      end
      for (int j = 0; j < 8; j++) begin
         cur_pos = 8'(($random(seed) & 32'h7FFF_FFFF) % 32'h0000_0064);
         {motor_busy, cur_dir, move_fault} = 3'($random(seed));
         repeat (2) @(posedge ref_clk);
         #1;
         v = ((cur_pos / 8'h0A) << 4) | (cur_pos % 8'h0A);
         cmp_stat(pos_out_n_r, move_fault ? 8'hFF : ~v);
         cmp_stat({7'h00, drive_active_n_r}, {7'h00, ~motor_busy});
         cmp_stat({7'h00, dir_out_n_r}, {7'h00, ~cur_dir});
         cmp_stat({7'h00, error_n_r}, {7'h00, ~move_fault});
      end
      do_reset(idxpio_pkg::IDXPIO_MODE_BIN);
      cmp_stat({6'h00, mode_r}, 8'h02);
      cmp_stat(8'(notes.size()), 8'h00);
      test_done();
   end
endmodule : test_indexer_parallel_io
